//--- fifo_flags_map.vh
`ifndef FIFO_FLAGS_MAP_VH
`define FIFO_FLAGS_MAP_VH

// register byte offsets
`define REG_EMPTY_OFFSET 8'h00
`define REG_FULL_OFFSET 8'h04
`define REG_STATUS 8'h08

// offset field width and reset value
`define OFS_WIDTH 16
`define OFS_DEFAULT 16'h0007

// status field positions
`define ST_FULL_N 0
`define ST_ALMOST_FULL_N 1
`define ST_ALMOST_EMPTY_N 2
`define ST_EMPTY_N 3
`define ST_TWO_ENABLE 4
`define ST_COUNT_LSB 16

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- ptr_sync_stage.v
`timescale 1ns/10ps
// two-stage pointer carrier between write and read sides
module ptr_sync_stage #(
  parameter WIDTH = 7
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pointer in and out
  input wire [WIDTH-1:0] ptr_in,
  output wire [WIDTH-1:0] ptr_out
);

reg [WIDTH-1:0] stage1_reg;
reg [WIDTH-1:0] stage2_reg;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    stage1_reg <= {WIDTH{1'b0}};
    stage2_reg <= {WIDTH{1'b0}};
  end
  else
  begin
    stage1_reg <= ptr_in;
    stage2_reg <= stage1_reg;
  end
end

assign ptr_out = stage2_reg;

endmodule

//--- dual_clock_fifo_status_flags.v
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "fifo_flags_map.vh"
module dual_clock_fifo_status_flags #(
  parameter DEPTH = 64,
  parameter DATA_W = 9,
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // write port
  input wire [DATA_W-1:0] write_data_in,
  input wire write_enable_a_n,
  input wire write_enable_b_or_load,
  // read port
  input wire read_enable_a_n,
  input wire read_enable_b_n,
  input wire output_enable_n,
  output wire [DATA_W-1:0] read_data_out,
  output wire read_data_oe,
  // status flags
  output wire full_flag_n,
  output wire almost_full_n,
  output wire almost_empty_n,
  output wire empty_flag_n,
  // axi4-lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

localparam AW = $clog2(DEPTH);
localparam CW = 18;
localparam [CW-1:0] DEPTH_X = DEPTH[CW-1:0];

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [AW:0] ptr_diff;
  input [AW:0] ahead;
  input [AW:0] behind;
  begin
    ptr_diff = ahead - behind;
  end
endfunction

function [CW-1:0] widen;
  input [AW:0] cnt;
  begin
    widen = {{(CW-AW-1){1'b0}}, cnt};
  end
endfunction

function [`OFS_WIDTH-1:0] merge_strb;
  input [`OFS_WIDTH-1:0] old_val;
  input [31:0] data;
  input [3:0] strb;
  begin
    merge_strb = old_val;
    if (strb[0])
      merge_strb[7:0] = data[7:0];
    if (strb[1])
      merge_strb[15:8] = data[15:8];
  end
endfunction

// ----------------------------------------------------------------
// storage and state
// ----------------------------------------------------------------
reg [DATA_W-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ptr_reg;
reg [AW:0] rd_ptr_reg;
reg [DATA_W-1:0] out_data_reg;
reg full_n_reg;
reg almost_full_n_reg;
reg almost_empty_n_reg;
reg empty_n_reg;
reg two_enable_reg;
reg [AW:0] wcount_reg;
reg [`OFS_WIDTH-1:0] empty_ofs_reg;
reg [`OFS_WIDTH-1:0] full_ofs_reg;
wire [AW:0] rd_ptr_sync;
wire [AW:0] wr_ptr_sync;

// ----------------------------------------------------------------
// pointer crossing
// ----------------------------------------------------------------
ptr_sync_stage #(.WIDTH(AW + 1)) u_rd_to_wr (
  .aclk(aclk),
  .aresetn(aresetn),
  .ptr_in(rd_ptr_reg),
  .ptr_out(rd_ptr_sync)
);

ptr_sync_stage #(.WIDTH(AW + 1)) u_wr_to_rd (
  .aclk(aclk),
  .aresetn(aresetn),
  .ptr_in(wr_ptr_reg),
  .ptr_out(wr_ptr_sync)
);

// ----------------------------------------------------------------
// effective offsets
// ----------------------------------------------------------------
wire [`OFS_WIDTH-1:0] full_m = two_enable_reg ? `OFS_DEFAULT : full_ofs_reg;
wire [`OFS_WIDTH-1:0] empty_n = two_enable_reg ? `OFS_DEFAULT : empty_ofs_reg;

// ----------------------------------------------------------------
// write side
// ----------------------------------------------------------------
wire wr_go = ~write_enable_a_n & write_enable_b_or_load & full_n_reg;
wire [AW:0] wr_ptr_next = wr_ptr_reg + {{AW{1'b0}}, wr_go};
wire [AW:0] wcount_next = ptr_diff(wr_ptr_next, rd_ptr_sync);
wire full_hit = widen(wcount_next) >= DEPTH_X;
wire afull_hit = (widen(wcount_next) + {2'b00, full_m}) >= DEPTH_X;

always @(posedge aclk)
begin
  if (wr_go)
    mem[wr_ptr_reg[AW-1:0]] <= write_data_in;
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    wr_ptr_reg <= {(AW+1){1'b0}};
    full_n_reg <= 1'b1;
    almost_full_n_reg <= 1'b1;
    wcount_reg <= {(AW+1){1'b0}};
  end
  else
  begin
    wr_ptr_reg <= wr_ptr_next;
    full_n_reg <= ~full_hit;
    almost_full_n_reg <= ~afull_hit;
    wcount_reg <= wcount_next;
  end
end

// ----------------------------------------------------------------
// read side
// ----------------------------------------------------------------
wire rd_go = ~read_enable_a_n & ~read_enable_b_n & empty_n_reg;
wire [AW:0] rd_ptr_next = rd_ptr_reg + {{AW{1'b0}}, rd_go};
wire [AW:0] rcount_next = ptr_diff(wr_ptr_sync, rd_ptr_next);
wire empty_hit = rcount_next == {(AW+1){1'b0}};
wire aempty_hit = widen(rcount_next) <= {2'b00, empty_n};

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    rd_ptr_reg <= {(AW+1){1'b0}};
    out_data_reg <= {DATA_W{1'b0}};
    empty_n_reg <= 1'b0;
    almost_empty_n_reg <= 1'b0;
  end
  else
  begin
    rd_ptr_reg <= rd_ptr_next;
    if (rd_go)
      out_data_reg <= mem[rd_ptr_reg[AW-1:0]];
    empty_n_reg <= ~empty_hit;
    almost_empty_n_reg <= ~aempty_hit;
  end
end

// ----------------------------------------------------------------
// mode strap and offsets
// ----------------------------------------------------------------
reg aw_hold_reg;
reg w_hold_reg;
reg [ADDR_W-1:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg bvalid_reg;
reg [1:0] bresp_reg;
reg rvalid_reg;
reg [31:0] rdata_reg;
reg [1:0] rresp_reg;
wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
wire [7:0] waddr = {{(8-ADDR_W){1'b0}}, aw_addr_reg} & 8'hff;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    two_enable_reg <= write_enable_b_or_load;
    empty_ofs_reg <= `OFS_DEFAULT;
    full_ofs_reg <= `OFS_DEFAULT;
  end
  else if (do_write && !two_enable_reg)
  begin
    if (waddr == `REG_EMPTY_OFFSET)
      empty_ofs_reg <= merge_strb(empty_ofs_reg, w_data_reg, w_strb_reg);
    else if (waddr == `REG_FULL_OFFSET)
      full_ofs_reg <= merge_strb(full_ofs_reg, w_data_reg, w_strb_reg);
  end
end

// ----------------------------------------------------------------
// axi4-lite write path
// ----------------------------------------------------------------
assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_hold_reg <= 1'b0;
    w_hold_reg <= 1'b0;
    aw_addr_reg <= {ADDR_W{1'b0}};
    w_data_reg <= 32'h0000_0000;
    w_strb_reg <= 4'h0;
    bvalid_reg <= 1'b0;
    bresp_reg <= `RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b1;
      if (waddr == `REG_EMPTY_OFFSET || waddr == `REG_FULL_OFFSET || waddr == `REG_STATUS)
        bresp_reg <= `RESP_OKAY;
      else
        bresp_reg <= `RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_reg <= 1'b0;
  end
end

// ----------------------------------------------------------------
// axi4-lite read path
// ----------------------------------------------------------------
wire [7:0] raddr = {{(8-ADDR_W){1'b0}}, s_axi_araddr} & 8'hff;
wire [31:0] status_word = {{(16-AW-1){1'b0}}, wcount_reg, 11'h000, two_enable_reg,
                           empty_n_reg, almost_empty_n_reg, almost_full_n_reg, full_n_reg};
assign s_axi_arready = ~rvalid_reg;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    rvalid_reg <= 1'b0;
    rdata_reg <= 32'h0000_0000;
    rresp_reg <= `RESP_OKAY;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    rvalid_reg <= 1'b1;
    rresp_reg <= `RESP_OKAY;
    if (raddr == `REG_EMPTY_OFFSET)
      rdata_reg <= {16'h0000, empty_n};
    else if (raddr == `REG_FULL_OFFSET)
      rdata_reg <= {16'h0000, full_m};
    else if (raddr == `REG_STATUS)
      rdata_reg <= status_word;
    else
    begin
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_SLVERR;
    end
  end
  else if (rvalid_reg && s_axi_rready)
    rvalid_reg <= 1'b0;
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign read_data_out = out_data_reg;
assign read_data_oe = ~output_enable_n;
assign full_flag_n = full_n_reg;
assign almost_full_n = almost_full_n_reg;
assign almost_empty_n = almost_empty_n_reg;
assign empty_flag_n = empty_n_reg;
assign s_axi_bvalid = bvalid_reg;
assign s_axi_bresp = bresp_reg;
assign s_axi_rvalid = rvalid_reg;
assign s_axi_rdata = rdata_reg;
assign s_axi_rresp = rresp_reg;

endmodule

//--- dual_clock_fifo_status_flags_monitor.sv
`timescale 1ns/10ps
module dual_clock_fifo_status_flags_monitor #(
  parameter DATA_W = 9
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // fifo pins
  input wire write_enable_a_n,
  input wire write_enable_b_or_load,
  input wire read_enable_a_n,
  input wire read_enable_b_n,
  input wire output_enable_n,
  input wire [DATA_W-1:0] read_data_out,
  input wire read_data_oe,
  input wire full_flag_n,
  input wire almost_full_n,
  input wire almost_empty_n,
  input wire empty_flag_n
);
  // ----
  // helper terms
  // ----
  wire wr_take = !write_enable_a_n && write_enable_b_or_load && full_flag_n;
  wire rd_take = !read_enable_a_n && !read_enable_b_n && empty_flag_n;
  reg [4:0] wr_hist;
  always @(posedge aclk)
  begin
    wr_hist <= {wr_hist[3:0], wr_take};
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // checks
  // ----
  reset_state_a:
    assert property (disable iff (1'b0) !aresetn |=> full_flag_n && almost_full_n
      && !empty_flag_n && !almost_empty_n && read_data_out == '0)
    else $error("reset state wrong");
  oe_follow_a:
    assert property (read_data_oe == !output_enable_n)
    else $error("output enable wrong");
  out_hold_a:
    assert property (read_enable_a_n || read_enable_b_n || !empty_flag_n
      |=> $stable(read_data_out))
    else $error("output moved without read");
  empty_rise_a:
    assert property ($rose(empty_flag_n) |-> |wr_hist[4:1])
    else $error("empty release without write");
  full_fall_a:
    assert property ($fell(full_flag_n) |-> $past(wr_take))
    else $error("full without write");
  af_fall_a:
    assert property ($fell(almost_full_n) |-> $past(wr_take))
    else $error("almost full without write");
  empty_fall_a:
    assert property ($fell(empty_flag_n) |-> $past(rd_take))
    else $error("empty without read");
  flag_nest_a:
    assert property ((!empty_flag_n |-> !almost_empty_n)
      and (!full_flag_n |-> !almost_full_n && almost_empty_n))
    else $error("flag states inconsistent");
  cover property (!full_flag_n);
  cover property ($rose(empty_flag_n));
  cover property (rd_take);
endmodule
bind dual_clock_fifo_status_flags dual_clock_fifo_status_flags_monitor
  #(.DATA_W(DATA_W)) mon (
  .aclk(aclk), .aresetn(aresetn), .write_enable_a_n(write_enable_a_n),
  .write_enable_b_or_load(write_enable_b_or_load), .read_enable_a_n(read_enable_a_n),
  .read_enable_b_n(read_enable_b_n), .output_enable_n(output_enable_n),
  .read_data_out(read_data_out), .read_data_oe(read_data_oe), .full_flag_n(full_flag_n),
  .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n), .empty_flag_n(empty_flag_n)
);

//--- fifo_side_model.sv
`timescale 1ns/10ps
module fifo_side_model (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bench commands
  input wire strap,
  input wire want_wr,
  input wire want_rd,
  input wire stall,
  input wire [8:0] data,
  // fifo pins
  output reg write_enable_a_n,
  output reg write_enable_b_or_load,
  output reg read_enable_a_n,
  output reg read_enable_b_n,
  output reg [8:0] write_data_in
);
  // ----
  // pin drive
  // ----
  always @(posedge aclk)
  begin
    write_enable_a_n <= !want_wr;
    write_enable_b_or_load <= aresetn ? !stall : strap;
    read_enable_a_n <= !want_rd;
    read_enable_b_n <= stall;
    write_data_in <= want_wr ? data : ~write_data_in;
  end
endmodule

//--- dual_clock_fifo_status_flags_tb.sv
`timescale 1ns/10ps
module dual_clock_fifo_status_flags_tb;
  // ----
  // signals
  // ----
  reg aclk, aresetn, output_enable_n, strap, want_wr, want_rd, stall, mode;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd_v, rnd;
  reg [8:0] data, q_exp;
  reg [8:0] sb[$];
  reg [1:0] rsp;
  wire [8:0] write_data_in, read_data_out;
  wire write_enable_a_n, write_enable_b_or_load, read_enable_a_n, read_enable_b_n;
  wire read_data_oe, full_flag_n, almost_full_n, almost_empty_n, empty_flag_n;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] s_axi_wstrb = 4'hf;
  wire [8:0] q_bus = read_data_oe ? read_data_out : {9{1'bz}};
  integer mismatches, total_checks, cnt, n_ofs, m_ofs;
  integer cyc = 0;
  dual_clock_fifo_status_flags #(.DEPTH(64)) dut (
    .aclk(aclk), .aresetn(aresetn), .write_data_in(write_data_in),
    .write_enable_a_n(write_enable_a_n), .write_enable_b_or_load(write_enable_b_or_load),
    .read_enable_a_n(read_enable_a_n), .read_enable_b_n(read_enable_b_n),
    .output_enable_n(output_enable_n), .read_data_out(read_data_out),
    .read_data_oe(read_data_oe), .full_flag_n(full_flag_n), .almost_full_n(almost_full_n),
    .almost_empty_n(almost_empty_n), .empty_flag_n(empty_flag_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  fifo_side_model peer (
    .aclk(aclk), .aresetn(aresetn), .strap(strap), .want_wr(want_wr), .want_rd(want_rd),
    .stall(stall), .data(data), .write_enable_a_n(write_enable_a_n),
    .write_enable_b_or_load(write_enable_b_or_load), .read_enable_a_n(read_enable_a_n),
    .read_enable_b_n(read_enable_b_n), .write_data_in(write_data_in)
  );
  initial
  begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  // ----
  // tasks
  // ----
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task chk_flags(input [3:0] got, input [31:0] exp);
  begin
    chk({28'h0000000, got}, exp & 32'h0000000f);
  end
  endtask
  task chk_q(input [8:0] got, input [8:0] exp);
  begin
    chk({23'h000000, got}, {23'h000000, exp});
  end
  endtask
  task chk_reg(input [31:0] got, input [31:0] exp);
  begin
    chk(got, exp);
  end
  endtask
  task chk_resp(input [1:0] got, input [1:0] exp);
  begin
    chk({30'h00000000, got}, {30'h00000000, exp});
  end
  endtask
  function [31:0] stat(input integer c);
    stat = {c[15:0], 11'h0, mode, c != 0, c > n_ofs, c < 64 - m_ofs, c != 64};
  endfunction
  task axi_wr(input [7:0] a, input [31:0] d);
    reg aw, w;
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    aw = 1;
    w = 1;
    while (aw || w)
    begin
      @(negedge aclk);
      if (s_axi_awready)
        aw = 0;
      if (s_axi_wready)
        w = 0;
      @(posedge aclk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1;
    do @(negedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 0;
  end
  endtask
  task axi_rd(input [7:0] a);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(negedge aclk); while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 0;
  end
  endtask
  task settle;
  begin
    repeat (6) @(posedge aclk);
    chk_flags({empty_flag_n, almost_empty_n, almost_full_n, full_flag_n}, stat(cnt));
    chk_q(q_bus, output_enable_n ? {9{1'bz}} : q_exp);
    axi_rd(8'h08);
    chk_reg(rd_v, stat(cnt));
  end
  endtask
  task step(input w);
  begin
    rnd = $urandom;
    stall <= rnd[0];
    output_enable_n <= rnd[1];
    data <= rnd[10:2];
    want_wr <= w;
    want_rd <= !w;
    @(posedge aclk);
    want_wr <= 0;
    want_rd <= 0;
    if (!stall && w && cnt < 64)
    begin
      sb.push_back(data);
      cnt = cnt + 1;
    end
    if (!stall && !w && cnt > 0)
    begin
      q_exp = sb.pop_front();
      cnt = cnt - 1;
    end
    settle;
  end
  endtask
  task do_reset(input s);
  begin
    aresetn <= 0;
    strap <= s;
    mode = s;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cnt = 0;
    n_ofs = 7;
    m_ofs = 7;
    q_exp = 0;
    sb.delete();
  end
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    {aresetn, output_enable_n, strap, want_wr, want_rd, stall, data} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    mismatches = 0;
    total_checks = 0;
    rnd = $urandom(81183);
    do_reset(1);
    settle;
    axi_wr(8'h04, 32'h00000003);
    axi_rd(8'h04);
    chk_reg(rd_v, 32'h00000007);
    axi_rd(8'h00);
    chk_reg(rd_v, 32'h00000007);
    axi_rd(8'h0c);
    chk_resp(rsp, 2'h2);
    while (cnt < 64) step(1);
    repeat (3) step(1);
    while (cnt > 0) step(0);
    repeat (3) step(0);
    $display("test 1 done");
    do_reset(0);
    axi_wr(8'h00, 32'h00000002);
    axi_wr(8'h04, 32'h00000003);
    chk_resp(rsp, 2'h0);
    axi_rd(8'h00);
    chk_reg(rd_v, 32'h00000002);
    axi_wr(8'h10, 32'h00000000);
    chk_resp(rsp, 2'h2);
    n_ofs = 2;
    m_ofs = 3;
    while (cnt < 64) step(1);
    while (cnt > 0) step(0);
    $display("test 2 done");
    wrap_up;
  end
endmodule
